// *** switch_csr_indirect_access.v ***
// axi4-lite bridge from the host into the switch fabric register space
`timescale 1ns/1ps
`include "switch_csr_map.vh"
module switch_csr_indirect_access #(
   parameter [31:0] PAUSE_LOW_DEFAULT = 32'h0012_3456  // arbitrary default address
) (
   // clock, reset, enable
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        clkEn,
   // axi4-lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [11:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [11:0] s_axi_araddr,
   // axi4-lite read data
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // switch fabric register port
   output wire        fabReq,
   output wire        fabRead,
   output reg  [15:0] fabAddr,
   output reg  [3:0]  fabByteSel,
   output wire [31:0] fabWriteMask,
   output reg  [31:0] fabWriteData,
   input  wire        fabAck,
   input  wire [31:0] fabReadData,
   // eeprom loader
   input  wire        eepromLoad,
   input  wire [47:0] eepromMac,
   input  wire        initDone,
   // mac addresses
   output reg  [15:0] pauseMacHigh,
   output reg  [31:0] pauseMacLow,
   output reg  [15:0] hostMacHigh,
   output reg  [31:0] hostMacLow
);
   // fabric engine states, one-hot
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_BUSY = 2'b10;

   reg  [1:0]  state;       // fabric engine state
   reg         dirRead;     // direction bit, 1 selects a read
   reg         stepUp;      // stored step-up mode bit
   reg         stepDown;    // stored step-down mode bit
   reg  [11:0] awAddrQ;     // captured write address
   reg         awHeld;      // write address waiting
   reg  [31:0] wDataQ;      // captured write data
   reg  [3:0]  wStrbQ;      // captured write strobes
   reg         wHeld;       // write data waiting
   reg  [31:0] readValue;   // read mux output
   reg         readHit;     // read address decoded
   wire [15:0] winAddr;     // fabric address of the window word
   wire        busy;        // transfer busy flag
   wire        doWrite;     // both write halves present this cycle
   wire        winHit;      // write address inside the window
   wire [11:0] winOffset;   // offset relative to window base
   wire [31:0] pauseHighMerged; // pause high merged with the bus bytes

   // merges bus bytes into an old value under the strobes
   function [31:0] mergeBytes;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0]  strb;
      integer k;
      begin
         mergeBytes = oldVal;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               mergeBytes[k*8 +: 8] = newVal[k*8 +: 8];
            end
         end
      end
   endfunction

   // true when a word address falls inside the write window
   function inWindow;
      input [11:0] addr;
      begin
         inWindow = (addr[11:2] >= `OFF_WIN_FIRST >> 2) && (addr[11:2] <= `OFF_WIN_LAST >> 2);
      end
   endfunction

   assign busy      = state[1];
   assign fabReq    = busy;            // level request until the fabric acks
   assign fabRead   = dirRead;
   assign winHit    = inWindow(awAddrQ);
   assign winOffset = awAddrQ - `OFF_WIN_FIRST;
   assign pauseHighMerged = mergeBytes({16'h0000, pauseMacHigh}, wDataQ, wStrbQ);

   // byte select expands to a 32-bit write mask, one lane per bit
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : laneMask
         assign fabWriteMask[g*8 +: 8] = {8{fabByteSel[g] & ~dirRead}};
      end
   endgenerate

   // window index to fabric register address
   switch_window_decode windowMap (
      .winIndex   (winOffset[7:2]),
      .fabricAddr (winAddr)
   );

   // channels accept only while no response is pending, one write at a time
   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;

   // write address and data capture, in either order
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld  <= 1'b0;
         awAddrQ <= 12'h000;
         wHeld   <= 1'b0;
         wDataQ  <= 32'h0000_0000;
         wStrbQ  <= 4'h0;
      end else if (clkEn) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld  <= 1'b1;
            awAddrQ <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld  <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   // write response, raised the cycle after both halves are present
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (clkEn) begin
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (winHit || awAddrQ[11:2] == `OFF_CMD >> 2 || awAddrQ[11:2] == `OFF_DATA >> 2 ||
                awAddrQ[11:2] == `OFF_PAUSE_HIGH >> 2 || awAddrQ[11:2] == `OFF_PAUSE_LOW >> 2) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_DECERR;  // unmapped
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // command, data and fabric engine; host writes to them are dropped while busy,
   // which keeps address and data stable for the whole transfer
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= ST_IDLE;
         dirRead      <= 1'b0;
         stepUp       <= 1'b0;
         stepDown     <= 1'b0;
         fabAddr      <= 16'h0000;
         fabByteSel   <= 4'h0;
         fabWriteData <= `RST_DATA;
      end else if (clkEn) begin
         case (state)
            ST_IDLE: begin
               if (doWrite && winHit) begin
                  // window write: mapped address, all bytes, write, go
                  fabAddr      <= winAddr;
                  fabByteSel   <= `BSEL_ALL;
                  dirRead      <= 1'b0;
                  fabWriteData <= mergeBytes(32'h0000_0000, wDataQ, wStrbQ);
                  state        <= ST_BUSY;
               end else if (doWrite && awAddrQ[11:2] == `OFF_CMD >> 2) begin
                  if (wStrbQ[0]) fabAddr[7:0] <= wDataQ[7:0];
                  if (wStrbQ[1]) fabAddr[15:8] <= wDataQ[15:8];
                  if (wStrbQ[2]) fabByteSel <= wDataQ[`CMD_BSEL_HI:`CMD_BSEL_LO];
                  if (wStrbQ[3]) begin
                     dirRead  <= wDataQ[`CMD_DIR_BIT];
                     stepUp   <= wDataQ[`CMD_STEP_UP_BIT];
                     stepDown <= wDataQ[`CMD_STEP_DN_BIT];
                     if (wDataQ[`CMD_BUSY_BIT]) begin
                        state <= ST_BUSY;
                     end
                  end
               end else if (doWrite && awAddrQ[11:2] == `OFF_DATA >> 2) begin
                  fabWriteData <= mergeBytes(fabWriteData, wDataQ, wStrbQ);
               end
            end
            ST_BUSY: begin
               // request held unchanged until the fabric acknowledges
               if (fabAck) begin
                  state <= ST_IDLE;
                  if (dirRead) begin
                     fabWriteData <= fabReadData;  // read result lands in data register
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // mac address registers; eeprom load wins over a host write in the same cycle;
   // host writes wait for init, so a load made before init is kept until init; after init the host may overwrite the pause registers
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pauseMacHigh <= `RST_PAUSE_HIGH;
         pauseMacLow  <= PAUSE_LOW_DEFAULT;  // fixed default
         hostMacHigh  <= `RST_PAUSE_HIGH;
         hostMacLow   <= PAUSE_LOW_DEFAULT;
      end else if (clkEn) begin
         if (eepromLoad) begin
            pauseMacHigh <= eepromMac[47:32];  // bytes 05h then 06h
            pauseMacLow  <= eepromMac[31:0];   // bytes 01h to 04h
            hostMacHigh  <= eepromMac[47:32];
            hostMacLow   <= eepromMac[31:0];
         end else if (initDone && doWrite && awAddrQ[11:2] == `OFF_PAUSE_HIGH >> 2) begin
            pauseMacHigh <= pauseHighMerged[15:0];
         end else if (initDone && doWrite && awAddrQ[11:2] == `OFF_PAUSE_LOW >> 2) begin
            pauseMacLow <= mergeBytes(pauseMacLow, wDataQ, wStrbQ);
         end
      end
   end

   // read decode; the window reads as zero since it is write-only
   always @* begin
      readHit   = 1'b1;
      readValue = 32'h0000_0000;
      case (s_axi_araddr[11:2])
         `OFF_CMD >> 2:
            readValue = {busy, dirRead, stepUp, stepDown, 8'h00, fabByteSel, fabAddr};
         `OFF_DATA >> 2:
            readValue = fabWriteData;
         `OFF_PAUSE_HIGH >> 2:
            readValue = {16'h0000, pauseMacHigh};
         `OFF_PAUSE_LOW >> 2:
            readValue = pauseMacLow;
         default: begin
            readHit = inWindow(s_axi_araddr);
         end
      endcase
   end

   // read data, answered the cycle after the address is taken
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readValue;
            s_axi_rresp  <= readHit ? `RESP_OKAY : `RESP_DECERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // switch_csr_indirect_access

// *** switch_csr_map.vh ***
// register offsets, field positions and reset values of the switch register bridge
// Behaviour
// - write only bytes whose select bit set
// - select bit n gates data byte n
// - command low 16 bits hold address, reset zero
// - pause high holds address bits 47:32, reset ones
// - eeprom bytes 05h,06h preload pause high
// - pause low holds bits 31:0, fixed default
// - eeprom bytes 01h..04h preload pause low
// - same eeprom bytes load host address registers
// - host may overwrite pause registers after init
// - write-only window 200h to 2DCh decoded
// - window write loads command and starts write
// - busy clears when window write completes
// - 200h maps 0001h, 204h maps 0004h
// - port registers map in groups of four
// - writing busy starts transfer, self-clears
// - direction bit zero writes, one reads
`ifndef SWITCH_CSR_MAP_VH
`define SWITCH_CSR_MAP_VH

// byte offsets on the host bus
`define OFF_CMD          12'h0b0
`define OFF_DATA         12'h0ac
`define OFF_PAUSE_HIGH   12'h1f0
`define OFF_PAUSE_LOW    12'h1f4
`define OFF_WIN_FIRST    12'h200
`define OFF_WIN_LAST     12'h2dc

// command register fields
`define CMD_BUSY_BIT     31
`define CMD_DIR_BIT      30
`define CMD_STEP_UP_BIT  29
`define CMD_STEP_DN_BIT  28
`define CMD_BSEL_HI      19
`define CMD_BSEL_LO      16
`define CMD_ADDR_HI      15
`define CMD_ADDR_LO      0

// reset values
`define RST_CMD          32'h0000_0000
`define RST_DATA         32'h0000_0000
`define RST_PAUSE_HIGH   16'hffff
`define BSEL_ALL         4'hf

// axi responses
`define RESP_OKAY        2'b00
`define RESP_DECERR      2'b11

`endif

// *** switch_window_decode.v ***
// maps a direct write window word index to its switch fabric register address
`timescale 1ns/1ps
module switch_window_decode (
   // window word index, offset 200h is index 0
   input  wire [5:0]  winIndex,
   // mapped fabric register address
   output reg  [15:0] fabricAddr
);
   reg [3:0] portIdx;  // index within the port section
   // ports repeat one four-entry pattern, so they are computed, the rest looked up
   always @* begin
      portIdx = 4'h0;
      case (winIndex)
         6'h00: fabricAddr = 16'h0001;
         6'h01: fabricAddr = 16'h0004;
         6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
         6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d: begin
            portIdx = winIndex[3:0] - 4'h2;
            // port base 0400h, 0800h, 0c00h plus one of four register slots
            fabricAddr = {4'h0, portIdx[3:2] + 2'h1, 2'b00, 8'h00};
            case (portIdx[1:0])
               2'd0:    fabricAddr[7:0] = 8'h01;
               2'd1:    fabricAddr[7:0] = 8'h40;
               2'd2:    fabricAddr[7:0] = 8'h41;
               default: fabricAddr[7:0] = 8'h80;
            endcase
         end
         // switch engine group
         6'h0e: fabricAddr = 16'h1800;
         6'h0f: fabricAddr = 16'h1801;
         6'h10: fabricAddr = 16'h1802;
         6'h11: fabricAddr = 16'h1809;
         6'h12: fabricAddr = 16'h180b;
         6'h13: fabricAddr = 16'h180c;
         6'h14: fabricAddr = 16'h1811;
         6'h15: fabricAddr = 16'h1812;
         6'h16: fabricAddr = 16'h1840;
         6'h17: fabricAddr = 16'h1841;
         6'h18: fabricAddr = 16'h1842;
         6'h19: fabricAddr = 16'h1843;
         6'h1a: fabricAddr = 16'h1845;
         6'h1b: fabricAddr = 16'h1846;
         6'h1c: fabricAddr = 16'h1847;
         6'h1d: fabricAddr = 16'h1848;
         6'h1e: fabricAddr = 16'h1849;
         6'h1f: fabricAddr = 16'h184a;
         6'h20: fabricAddr = 16'h184b;
         6'h21: fabricAddr = 16'h184d;
         6'h22: fabricAddr = 16'h1855;
         6'h23: fabricAddr = 16'h1856;
         6'h24: fabricAddr = 16'h1857;
         6'h25: fabricAddr = 16'h1880;
         // buffer manager group
         6'h26: fabricAddr = 16'h1c00;
         6'h27: fabricAddr = 16'h1c01;
         6'h28: fabricAddr = 16'h1c02;
         6'h29: fabricAddr = 16'h1c03;
         6'h2a: fabricAddr = 16'h1c04;
         6'h2b: fabricAddr = 16'h1c09;
         6'h2c: fabricAddr = 16'h1c0a;
         6'h2d: fabricAddr = 16'h1c0c;
         6'h2e: fabricAddr = 16'h1c0d;
         6'h2f: fabricAddr = 16'h1c0e;
         6'h30: fabricAddr = 16'h1c0f;
         6'h31: fabricAddr = 16'h1c10;
         6'h32: fabricAddr = 16'h1c11;
         6'h33: fabricAddr = 16'h1c12;
         6'h34: fabricAddr = 16'h1c13;
         6'h35: fabricAddr = 16'h1c14;
         6'h36: fabricAddr = 16'h1c15;
         6'h37: fabricAddr = 16'h1c20;
         default: fabricAddr = 16'h0000;  // outside the window, never used
      endcase
   end
endmodule // switch_window_decode

// *** switch_csr_checker.sv ***
// assertion checker for the switch register bridge
`timescale 1ns/1ps
module switch_csr_checker #(
   parameter [31:0] PAUSE_LOW_DEFAULT = 32'h0012_3456  // arbitrary default address
) (
   // clock, reset, enable
   input wire        core_clk,
   input wire        rst_n,
   input wire        clkEn,
   // bus write response
   input wire        s_axi_bvalid,
   // fabric port
   input wire        fabReq,
   input wire        fabRead,
   input wire        fabAck,
   input wire [15:0] fabAddr,
   input wire [3:0]  fabByteSel,
   input wire [31:0] fabWriteMask,
   input wire [31:0] fabWriteData,
   // address loading
   input wire        eepromLoad,
   input wire [47:0] eepromMac,
   input wire        initDone,
   input wire [15:0] pauseMacHigh,
   input wire [31:0] pauseMacLow,
   input wire [15:0] hostMacHigh,
   input wire [31:0] hostMacLow
);
   // one domain, so clock and reset are given once
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // a request must not move under the fabric before it is acknowledged
   AST_REQ_HOLD: assert property (fabReq && !fabAck |=> fabReq && $stable(fabAddr)
      && $stable(fabWriteData) && $stable(fabByteSel) && $stable(fabRead))
      else $error("fabric request changed before ack");
   AST_REQ_DONE: assert property (fabReq && fabAck && clkEn |=> !fabReq)
      else $error("busy did not clear after ack");
   AST_LANE_MASK: assert property (fabReq && !fabRead |-> fabWriteMask ==
      {{8{fabByteSel[3]}}, {8{fabByteSel[2]}}, {8{fabByteSel[1]}}, {8{fabByteSel[0]}}})
      else $error("write mask does not follow byte select");
   AST_READ_NOMASK: assert property (fabReq && fabRead |-> fabWriteMask == 32'h0)
      else $error("read carries a write mask");
   AST_LAUNCH: assert property ($rose(fabReq) |-> $rose(s_axi_bvalid))
      else $error("fabric request without a bus write");
   AST_EE_LOAD: assert property (eepromLoad && clkEn |=>
      {pauseMacHigh, pauseMacLow} == $past(eepromMac))
      else $error("pause address not loaded");
   AST_EE_HOST: assert property (eepromLoad && clkEn |=>
      {hostMacHigh, hostMacLow} == $past(eepromMac))
      else $error("host address not loaded");
   AST_LOCKED: assert property (!initDone && !eepromLoad |=> $stable(pauseMacHigh))
      else $error("pause high changed before init");
   AST_LOW_DEFAULT: assert property ($rose(rst_n) |->
      pauseMacLow == PAUSE_LOW_DEFAULT && hostMacLow == PAUSE_LOW_DEFAULT)
      else $error("pause low lost its default");
endmodule // switch_csr_checker

bind switch_csr_indirect_access switch_csr_checker #(.PAUSE_LOW_DEFAULT(PAUSE_LOW_DEFAULT)) i_chk (
   .core_clk, .rst_n, .clkEn, .s_axi_bvalid, .fabReq, .fabRead, .fabAck, .fabAddr,
   .fabByteSel, .fabWriteMask, .fabWriteData, .eepromLoad, .eepromMac, .initDone,
   .pauseMacHigh, .pauseMacLow, .hostMacHigh, .hostMacLow);

// *** fabric_model.sv ***
// behavioural model of the switch fabric register space
`timescale 1ns/1ps
module fabric_model (
   // clock and reset
   input  wire         core_clk,
   input  wire         rst_n,
   // request from the bridge
   input  wire         fabReq,
   input  wire         fabRead,
   input  wire [15:0]  fabAddr,
   input  wire [3:0]   fabByteSel,
   input  wire [31:0]  fabWriteMask,
   input  wire [31:0]  fabWriteData,
   // answer to the bridge
   output logic        fabAck,
   output logic [31:0] fabReadData
);
   logic [31:0] mem [0:65535];  // register contents, preset to a known pattern
   logic [2:0]  waitCnt;        // cycles spent on the current request
   logic        slow;           // alternates prompt and slow answers
   logic [15:0] lastAddr;       // last completed request, for the bench
   logic [3:0]  lastSel;
   logic        lastRead;

   initial foreach (mem[i]) mem[i] = 32'h5a5a_5a5a;

   // answer each request once; read data is only valid with the ack
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fabAck <= 1'b0;
         waitCnt <= 3'h0;
         slow <= 1'b0;
         fabReadData <= 32'h0;
      end else if (fabReq && !fabAck && waitCnt == (slow ? 3'h5 : 3'h0)) begin
         fabAck <= 1'b1;
         waitCnt <= 3'h0;
         slow <= !slow;
         lastAddr <= fabAddr;
         lastSel <= fabByteSel;
         lastRead <= fabRead;
         if (fabRead) fabReadData <= mem[fabAddr];
         else mem[fabAddr] <= (mem[fabAddr] & ~fabWriteMask) | (fabWriteData & fabWriteMask);
      end else begin
         // outside the ack the data bus toggles so stale values never pass
         if (fabReq && !fabAck) waitCnt <= waitCnt + 3'h1;
         fabAck <= 1'b0;
         fabReadData <= ~fabReadData;
      end
   end
endmodule // fabric_model

// *** switch_csr_indirect_access_tb_top.sv ***
// self-checking bench for the switch register bridge
`timescale 1ns/1ps
`include "switch_csr_map.vh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %0t: got %h want %h", $time, g, e); end end
module switch_csr_indirect_access_tb_top;
   localparam [31:0] LOW_DEF = 32'h00a1_b2c3;  // arbitrary default address
   // bench drive, all set at time zero
   logic core_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1, eepromLoad = 0, initDone = 0, clkEn = 1;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   logic [47:0] eepromMac = 0;
   // design and fabric model outputs
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fabReq, fabRead;
   wire fabAck;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, fabWriteMask, fabWriteData, fabReadData, pauseMacLow, hostMacLow;
   wire [15:0] fabAddr, pauseMacHigh, hostMacHigh;
   wire [3:0]  fabByteSel;
   int miscompares = 0, nTests = 0, cycles = 0;

   switch_csr_indirect_access #(.PAUSE_LOW_DEFAULT(LOW_DEF)) i_dut (.core_clk, .rst_n,
      .clkEn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .fabReq, .fabRead, .fabAddr, .fabByteSel, .fabWriteMask, .fabWriteData, .fabAck,
      .fabReadData, .eepromLoad, .eepromMac, .initDone, .pauseMacHigh, .pauseMacLow,
      .hostMacHigh, .hostMacLow);
   fabric_model i_fab (.core_clk, .rst_n, .fabReq, .fabRead, .fabAddr, .fabByteSel,
      .fabWriteMask, .fabWriteData, .fabAck, .fabReadData);

   initial forever #5 core_clk = ~core_clk;

   // hang guard, far above the 150 or so cycles the run needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         wrapUp();
      end
   end

   // ready is sampled mid-cycle; it only changes on the rising edge
   task automatic axiWr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
      logic aDone, wDone, ok;
      aDone = 0;
      wDone = 0;
      s_axi_awvalid <= 1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      do begin
         @(negedge core_clk);
         ok = !aDone && s_axi_awready;
         aDone |= s_axi_awready;
         wDone |= s_axi_wready;
         @(posedge core_clk);
         if (ok) s_axi_awvalid <= 0;
         if (wDone) s_axi_wvalid <= 0;
      end while (!(aDone && wDone));
      do begin
         @(negedge core_clk);
         ok = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge core_clk);
      end while (!ok);
   endtask

   task automatic axiRd(input [11:0] a, output [31:0] d, output [1:0] r);
      logic ok;
      s_axi_arvalid <= 1;
      s_axi_araddr <= a;
      do begin
         @(negedge core_clk);
         ok = s_axi_arready;
         @(posedge core_clk);
      end while (!ok);
      s_axi_arvalid <= 0;
      do begin
         @(negedge core_clk);
         ok = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk);
      end while (!ok);
   endtask

   // poll the command register until the transfer is over
   task automatic waitIdle(output [31:0] d);
      logic [1:0] r;
      do axiRd(`OFF_CMD, d, r); while (d[`CMD_BUSY_BIT] !== 1'b0);
   endtask

   task automatic tReset();
      logic [31:0] d;
      logic [1:0]  r;
      axiRd(`OFF_CMD, d, r);
      `CHK(d, `RST_CMD)
      axiRd(`OFF_PAUSE_HIGH, d, r);
      `CHK(d[15:0], `RST_PAUSE_HIGH)
      axiRd(`OFF_PAUSE_LOW, d, r);
      `CHK(d, LOW_DEF)
   endtask

   // every window block except the switch engine group, first and last word included
   task automatic tWindow();
      logic [11:0] off [9] = '{12'h200, 12'h204, 12'h208, 12'h20c, 12'h210, 12'h214,
                               12'h218, 12'h228, 12'h2dc};
      logic [15:0] map [9] = '{16'h0001, 16'h0004, 16'h0401, 16'h0440, 16'h0441, 16'h0480,
                               16'h0801, 16'h0c01, 16'h1c20};
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 9; i++) begin
         axiWr(off[i], 32'hc3e1_0000 + i, 4'hf, r);
         `CHK(r, `RESP_OKAY)
         waitIdle(d);
         `CHK(d, {12'h000, `BSEL_ALL, map[i]})
         `CHK(i_fab.lastAddr, map[i])
         `CHK({i_fab.lastRead, i_fab.lastSel}, {1'b0, `BSEL_ALL})
         `CHK(i_fab.mem[map[i]], 32'hc3e1_0000 + i)
      end
      // reads go through command and data registers, never the window
      axiWr(`OFF_CMD, 32'hc00f_0004, 4'hf, r);
      waitIdle(d);
      axiRd(`OFF_DATA, d, r);
      `CHK({r, d}, {`RESP_OKAY, 32'hc3e1_0001})
      axiWr(12'h2e0, 32'h1, 4'hf, r);
      `CHK(r, `RESP_DECERR)
      axiRd(12'h3f0, d, r);
      `CHK(r, `RESP_DECERR)
   endtask

   // partial-lane write, then a read back through the data register
   task automatic tIndirect();
      logic [31:0] d;
      logic [1:0]  r;
      axiWr(`OFF_DATA, 32'h1122_3344, 4'hf, r);
      axiWr(`OFF_CMD, 32'h8005_1234, 4'hf, r);
      waitIdle(d);
      `CHK(d, 32'h0005_1234)
      `CHK(i_fab.mem[16'h1234], 32'h5a22_5a44)
      axiWr(`OFF_CMD, 32'hc00f_1234, 4'hf, r);
      waitIdle(d);
      `CHK(i_fab.lastRead, 1'b1)
      axiRd(`OFF_DATA, d, r);
      `CHK(d, 32'h5a22_5a44)
      // step mode stored with every byte select set
      axiWr(`OFF_CMD, 32'h200f_0010, 4'hf, r);
      axiRd(`OFF_CMD, d, r);
      `CHK(d, 32'h200f_0010)
   endtask

   task automatic tEeprom();
      logic [31:0] d;
      logic [1:0]  r;
      axiWr(`OFF_PAUSE_HIGH, 32'h0000_1357, 4'hf, r);
      axiRd(`OFF_PAUSE_HIGH, d, r);
      `CHK(d[15:0], `RST_PAUSE_HIGH)
      clkEn <= 0;  // frozen: the load must wait
      eepromMac <= 48'h6655_4433_2211;
      eepromLoad <= 1;
      @(posedge core_clk);
      clkEn <= 1;
      initDone <= 1;
      @(negedge core_clk);
      `CHK(pauseMacLow, LOW_DEF)
      @(posedge core_clk);
      eepromLoad <= 0;
      @(negedge core_clk);
      `CHK({pauseMacHigh, pauseMacLow}, 48'h6655_4433_2211)
      `CHK({hostMacHigh, hostMacLow}, 48'h6655_4433_2211)
      @(posedge core_clk);
      axiWr(`OFF_PAUSE_LOW, 32'hdead_beef, 4'hf, r);
      axiRd(`OFF_PAUSE_LOW, d, r);
      `CHK(d, 32'hdead_beef)
      `CHK(pauseMacLow, 32'hdead_beef)
   endtask

   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1;
      @(posedge core_clk);
      tReset();
      tWindow();
      tIndirect();
      tEeprom();
      wrapUp();
   end
endmodule // switch_csr_indirect_access_tb_top
